/* rtl/sew_defs.svh */
/*
 * Constants of the serial word memory: geometry, opcodes, timing.
 * Assumes the includer works on a 20 MHz system clock.
 */
`ifndef SEW_DEFS_SVH
`define SEW_DEFS_SVH

// ====================================================================
// Geometry
`define SEW_WORDS      256
`define SEW_DATA_W     16
`define SEW_ADDR_W     8
`define SEW_OP_W       2
`define SEW_FIFO_DEPTH 16

// ====================================================================
// Opcodes and sub-codes
`define SEW_OP_EXT     2'h0
`define SEW_OP_WRITE   2'h1
`define SEW_OP_READ    2'h2
`define SEW_OP_ERASE   2'h3
`define SEW_SUB_LOCK   2'h0
`define SEW_SUB_FILL   2'h1
`define SEW_SUB_CLEAR  2'h2
`define SEW_SUB_ENABLE 2'h3
`define SEW_ERASED     16'hffff

// ====================================================================
// Timing
`define SEW_CLK_NS     50
`define SEW_ERASE_NS   5000
`define SEW_WRITE_NS   5000
`define SEW_ERASE_CYC  ((`SEW_ERASE_NS + `SEW_CLK_NS - 1) / `SEW_CLK_NS)
`define SEW_WRITE_CYC  ((`SEW_WRITE_NS + `SEW_CLK_NS - 1) / `SEW_CLK_NS)

`endif

/* rtl/sew_pkg.sv */
/*
 * Types of the serial word memory.
 * Assumes sew_defs.svh sits on the include path.
 */
`default_nettype none
`include "sew_defs.svh"

package sew_pkg;
	typedef enum logic [2:0] {S_IDLE, S_OP, S_ADDR, S_DATA, S_ARMED, S_READ, S_HOLD} sew_dec_t;
	typedef enum logic [1:0] {P_IDLE, P_ERASE, P_WRITE} sew_eng_t;
	typedef struct packed {
		logic                    all;
		logic [`SEW_ADDR_W-1:0]  addr;
		logic [`SEW_DATA_W-1:0]  data;
	} sew_cmd_t;
endpackage

`default_nettype wire

/* rtl/sew_top.sv */
/*
 * Serial word memory: frame decoder, read streamer, write-enable latch,
 * programming command FIFO and self-timed programming engine.
 * Assumes cs_in, serial_clk_in and din_in are synchronous to mclk_in and
 * that the serial clock is far slower than mclk_in.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sew_defs.svh"

// ====================================================================
// Command FIFO
module sew_fifo #(
	parameter int WIDTH = 25,
	parameter int DEPTH = `SEW_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic             mclk_in,
	input  wire logic             rst_b_in,
	// Fill side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] store_reg [DEPTH];
	logic [PW:0]      wr_ptr_reg;
	logic [PW:0]      rd_ptr_reg;
	logic             push;
	logic             pop;

	assign in_ready_out  = (wr_ptr_reg - rd_ptr_reg) != (PW+1)'(DEPTH);
	assign out_valid_out = wr_ptr_reg != rd_ptr_reg;
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;
	assign out_data_out  = store_reg[rd_ptr_reg[PW-1:0]];

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (push)
			store_reg[wr_ptr_reg[PW-1:0]] <= in_data_in;
	end
endmodule

// ====================================================================
// Device top
module sew_top import sew_pkg::*; #(
	parameter int ERASE_CYC = `SEW_ERASE_CYC,
	parameter int WRITE_CYC = `SEW_WRITE_CYC
) (
	// Clock and reset
	input  wire logic mclk_in,
	input  wire logic rst_b_in,
	// Serial link
	input  wire logic cs_in,
	input  wire logic serial_clk_in,
	input  wire logic din_in,
	output logic      dout_out,
	output logic      dout_oe_b_out
);
	localparam int CW = 16;
	localparam int CMD_W = $bits(sew_cmd_t);

	logic [`SEW_DATA_W-1:0] mem [`SEW_WORDS];
	sew_dec_t               dec_st_reg;
	sew_eng_t               eng_st_reg;
	logic [4:0]             bit_cnt_reg;
	logic [`SEW_OP_W-1:0]   op_reg;
	logic [`SEW_ADDR_W-1:0] addr_reg;
	logic [`SEW_DATA_W-1:0] data_reg;
	logic [`SEW_DATA_W-1:0] rd_sh_reg;
	logic [`SEW_ADDR_W-1:0] rd_addr_reg;
	logic [3:0]             rd_cnt_reg;
	logic [CW-1:0]          eng_cnt_reg;
	sew_cmd_t               cur_reg;
	logic sk_q_reg, cs_q_reg, wel_reg, status_reg, dout_reg;
	logic sk_rise, cs_fall, addr_done, enable_cmd, lock_cmd;
	logic push, fifo_ready, fifo_valid, pop, busy, mem_we;
	logic [`SEW_ADDR_W-1:0] addr_full;
	logic [1:0]             sub;
	sew_cmd_t               push_cmd;
	logic [CMD_W-1:0]       pop_bits;
	logic [`SEW_DATA_W-1:0] mem_wdata;

	// ================================================================
	// Edge detection and decode strobes
	// With select high, all frame logic waits on sk_rise, so a stopped clock freezes it
	assign sk_rise    = serial_clk_in && !sk_q_reg;
	assign cs_fall    = cs_q_reg && !cs_in;
	assign addr_done  = sk_rise && cs_in && dec_st_reg == S_ADDR && bit_cnt_reg == 5'h7;
	assign addr_full  = {addr_reg[`SEW_ADDR_W-2:0], din_in};
	assign sub        = addr_full[`SEW_ADDR_W-1 -: 2];
	assign enable_cmd = addr_done && op_reg == `SEW_OP_EXT && sub == `SEW_SUB_ENABLE;
	assign lock_cmd   = addr_done && op_reg == `SEW_OP_EXT && sub == `SEW_SUB_LOCK;

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sk_q_reg <= 1'b0;
			cs_q_reg <= 1'b0;
		end else begin
			sk_q_reg <= serial_clk_in;
			cs_q_reg <= cs_in;
		end
	end

	// ================================================================
	// Frame decoder
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			dec_st_reg  <= S_IDLE;
			bit_cnt_reg <= '0;
		end else if (!cs_in) begin
			dec_st_reg  <= S_IDLE;
			bit_cnt_reg <= '0;
		end else if (sk_rise) begin
			bit_cnt_reg <= bit_cnt_reg + 5'h1;
			case (dec_st_reg)
				S_IDLE: begin
					bit_cnt_reg <= '0;
					// Refusing new frames while the FIFO is full stalls the host
					if (din_in && fifo_ready)
						dec_st_reg <= S_OP;
				end
				S_OP: begin
					if (bit_cnt_reg == 5'h1) begin
						dec_st_reg  <= S_ADDR;
						bit_cnt_reg <= '0;
					end
				end
				S_ADDR: begin
					if (bit_cnt_reg == 5'h7) begin
						if (op_reg == `SEW_OP_READ)
							dec_st_reg <= S_READ;
						else if (op_reg == `SEW_OP_WRITE)
							dec_st_reg <= S_DATA;
						else if (op_reg == `SEW_OP_ERASE)
							dec_st_reg <= S_ARMED;
						else if (sub == `SEW_SUB_FILL)
							dec_st_reg <= S_DATA;
						else if (sub == `SEW_SUB_CLEAR)
							dec_st_reg <= S_ARMED;
						else
							dec_st_reg <= S_HOLD;
					end
				end
				default: begin
					dec_st_reg <= dec_st_reg;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			op_reg   <= '0;
			addr_reg <= '0;
			data_reg <= '0;
		end else if (sk_rise && cs_in) begin
			if (dec_st_reg == S_OP)
				op_reg <= {op_reg[0], din_in};
			if (dec_st_reg == S_ADDR)
				addr_reg <= addr_full;
			// Longer bursts keep only the newest 16 bits
			if (dec_st_reg == S_DATA)
				data_reg <= {data_reg[`SEW_DATA_W-2:0], din_in};
		end
	end

	// ================================================================
	// Write-enable latch; reads never look at it
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			wel_reg <= 1'b0;
		else if (lock_cmd)
			wel_reg <= 1'b0;
		else if (enable_cmd)
			wel_reg <= 1'b1;
	end

	// ================================================================
	// Read streamer and data output
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_sh_reg   <= '0;
			rd_addr_reg <= '0;
			rd_cnt_reg  <= '0;
			dout_reg    <= 1'b0;
		end else if (addr_done && op_reg == `SEW_OP_READ) begin
			rd_sh_reg   <= mem[addr_full];
			rd_addr_reg <= addr_full;
			rd_cnt_reg  <= '0;
			dout_reg    <= 1'b0;
		end else if (sk_rise && cs_in && dec_st_reg == S_READ) begin
			dout_reg   <= rd_sh_reg[`SEW_DATA_W-1];
			rd_cnt_reg <= rd_cnt_reg + 4'h1;
			if (rd_cnt_reg == 4'hf) begin
				// Eight-bit address rolls over from the top word to zero
				rd_addr_reg <= rd_addr_reg + 8'h1;
				rd_sh_reg   <= mem[rd_addr_reg + 8'h1];
			end else begin
				rd_sh_reg <= {rd_sh_reg[`SEW_DATA_W-2:0], 1'b0};
			end
		end else if (status_reg) begin
			dout_reg <= !busy;
		end
	end

	assign dout_out      = dout_reg;
	assign dout_oe_b_out = !(cs_in && (dec_st_reg == S_READ || status_reg));

	// ================================================================
	// Launch of programming frames
	assign push = cs_fall && wel_reg && (dec_st_reg == S_DATA || dec_st_reg == S_ARMED);
	always_comb begin
		push_cmd.all  = op_reg == `SEW_OP_EXT;
		push_cmd.addr = addr_reg;
		push_cmd.data = data_reg;
		if (dec_st_reg == S_ARMED)
			push_cmd.data = `SEW_ERASED;
	end

	// Status shown from launch until a clock rise with data high
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			status_reg <= 1'b0;
		else if (push)
			status_reg <= 1'b1;
		else if (sk_rise && cs_in && din_in)
			status_reg <= 1'b0;
	end

	sew_fifo #(.WIDTH(CMD_W), .DEPTH(`SEW_FIFO_DEPTH)) u_fifo (
		.mclk_in       (mclk_in),
		.rst_b_in      (rst_b_in),
		.in_valid_in   (push),
		.in_ready_out  (fifo_ready),
		.in_data_in    (push_cmd),
		.out_valid_out (fifo_valid),
		.out_ready_in  (eng_st_reg == P_IDLE),
		.out_data_out  (pop_bits)
	);

	// ================================================================
	// Self-timed programming engine
	assign pop  = fifo_valid && eng_st_reg == P_IDLE;
	assign busy = fifo_valid || eng_st_reg != P_IDLE;

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			eng_st_reg  <= P_IDLE;
			eng_cnt_reg <= '0;
			cur_reg     <= '0;
		end else begin
			eng_cnt_reg <= eng_cnt_reg - 1'b1;
			case (eng_st_reg)
				P_IDLE: begin
					if (pop) begin
						cur_reg     <= sew_cmd_t'(pop_bits);
						eng_st_reg  <= P_ERASE;
						eng_cnt_reg <= CW'(ERASE_CYC - 1);
					end
				end
				P_ERASE: begin
					if (eng_cnt_reg == '0) begin
						eng_st_reg  <= P_WRITE;
						eng_cnt_reg <= CW'(WRITE_CYC - 1);
					end
				end
				default: begin
					if (eng_cnt_reg == '0)
						eng_st_reg <= P_IDLE;
				end
			endcase
		end
	end

	assign mem_we    = eng_st_reg != P_IDLE && eng_cnt_reg == '0;
	assign mem_wdata = eng_st_reg == P_ERASE ? `SEW_ERASED : cur_reg.data;

	// Array words: nonvolatile, so no reset
	for (genvar i = 0; i < `SEW_WORDS; i++) begin : g_word
		always_ff @(posedge mclk_in) begin
			if (mem_we && (cur_reg.all || cur_reg.addr == 8'(i)))
				mem[i] <= mem_wdata;
		end
	end

	// ================================================================
	// Checks
	sequence s_launch;
		cs_q_reg && !cs_in && wel_reg && dec_st_reg == S_ARMED;
	endsequence
	sequence s_erase_end;
		eng_st_reg == P_ERASE && eng_cnt_reg == '0;
	endsequence

	property p_hold;
		@(posedge mclk_in) disable iff (!rst_b_in) (cs_in && !sk_rise) |=> $stable(dec_st_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("Decoder moved without clock");

	property p_lead_zero;
		@(posedge mclk_in) disable iff (!rst_b_in) $rose(dec_st_reg == S_READ) |-> !dout_reg;
	endproperty
	a_lead_zero: assert property (p_lead_zero) else $error("No leading zero");

	property p_sk_edge;
		@(posedge mclk_in) disable iff (!rst_b_in)
			(dec_st_reg == S_READ && $past(dec_st_reg == S_READ) && !$past(sk_rise)) |-> $stable(dout_reg);
	endproperty
	a_sk_edge: assert property (p_sk_edge) else $error("Read data moved off edge");

	property p_wrap;
		@(posedge mclk_in) disable iff (!rst_b_in)
			(sk_rise && cs_in && dec_st_reg == S_READ && rd_cnt_reg == 4'hf) |=>
				rd_addr_reg == $past(rd_addr_reg) + 8'h1;
	endproperty
	a_wrap: assert property (p_wrap) else $error("Address did not advance");

	property p_locked;
		@(posedge mclk_in) disable iff (!rst_b_in)
			(cs_fall && !wel_reg) |=> $stable(status_reg) && !$rose(fifo_valid);
	endproperty
	a_locked: assert property (p_locked) else $error("Program while locked");

	property p_sticky;
		@(posedge mclk_in) disable iff (!rst_b_in) (wel_reg && !lock_cmd) |=> wel_reg;
	endproperty
	a_sticky: assert property (p_sticky) else $error("Latch dropped");

	property p_lock;
		@(posedge mclk_in) disable iff (!rst_b_in) lock_cmd |=> !wel_reg;
	endproperty
	a_lock: assert property (p_lock) else $error("Lock ignored");

	property p_launch;
		@(posedge mclk_in) disable iff (!rst_b_in) s_launch |=> busy ##1 busy;
	endproperty
	a_launch: assert property (p_launch) else $error("Launch not busy");

	property p_erase_first;
		@(posedge mclk_in) disable iff (!rst_b_in) s_erase_end |=> eng_st_reg == P_WRITE;
	endproperty
	a_erase_first: assert property (p_erase_first) else $error("Write skipped");

	property p_status;
		@(posedge mclk_in) disable iff (!rst_b_in)
			(status_reg && dec_st_reg != S_READ) |=> dout_reg != $past(busy);
	endproperty
	a_status: assert property (p_status) else $error("Wrong ready status");

	property p_clear;
		@(posedge mclk_in) disable iff (!rst_b_in) (sk_rise && cs_in && din_in) |=> !status_reg;
	endproperty
	a_clear: assert property (p_clear) else $error("Status not cleared");
endmodule

`default_nettype wire

/* dv/sew_host_model.sv */
/*
 * Host side model of the serial word memory link: frames and status polls.
 * Assumes the bench calls its tasks one at a time from a single process.
 */
`timescale 1ns/1ps
`default_nettype none

module sew_host_model (
	// System clock
	input  wire logic mclk_in,
	// Serial link
	output logic      cs_out,
	output logic      serial_clk_out,
	output logic      din_out,
	input  wire logic dout_in
);
	// ====================================================================
	// Timing
	// Each serial level held 4 mclk, twice the device minimum
	localparam int HALF   = 4;
	localparam int CS_LOW = 6;

	initial begin
		cs_out = 1'b0;
		serial_clk_out = 1'b0;
		din_out = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask

	// ====================================================================
	// Frames
	// Bits go out most significant first; clock idles low between frames
	task automatic send(input logic [31:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			din_out = v[i];
			tick(HALF);
			serial_clk_out = 1'b1;
			tick(HALF);
			serial_clk_out = 1'b0;
		end
	endtask

	task automatic start_frame();
		cs_out = 1'b1;
		tick(HALF);
	endtask

	// Select drops in the low phase after the last bit, before any rise
	// Held low past the 250 ns minimum before any status poll
	task automatic end_frame();
		cs_out = 1'b0;
		din_out = 1'b0;
		tick(CS_LOW);
	endtask

	// Data held low so the poll itself never wipes the status
	task automatic raise_cs();
		din_out = 1'b0;
		cs_out = 1'b1;
		tick(2);
	endtask

	// Output seen just before a rise and half a period after it
	task automatic rise_read(output logic pre_rise, output logic post_rise);
		din_out = 1'b0;
		tick(HALF);
		pre_rise = dout_in;
		serial_clk_out = 1'b1;
		tick(HALF);
		post_rise = dout_in;
		serial_clk_out = 1'b0;
	endtask
endmodule

`default_nettype wire

/* dv/tb_serial_eeprom_word_interface.sv */
/*
 * Self-checking bench of the serial word memory top.
 * Assumes the host model drives the link and the design carries its own assertions.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sew_defs.svh"

module tb_serial_eeprom_word_interface;
	// ====================================================================
	// Clock, reset, link
	// Short programming phases keep the run small
	localparam int PROG_CYC = 8;
	localparam int LIMIT    = 20000;
	logic mclk_in  = 1'b0;
	logic rst_b_in = 1'b0;
	logic cs_in;
	logic serial_clk_in;
	logic din_in;
	logic dout_out;
	logic dout_oe_b_out;
	wire  logic dout_line;
	int   n_mismatch  = 0;
	int   checks_done = 0;
	int   cycles      = 0;

	always #25 mclk_in = ~mclk_in;

	sew_top #(.ERASE_CYC(PROG_CYC), .WRITE_CYC(PROG_CYC)) sew_top_i (
		.mclk_in(mclk_in), .rst_b_in(rst_b_in), .cs_in(cs_in), .serial_clk_in(serial_clk_in),
		.din_in(din_in), .dout_out(dout_out), .dout_oe_b_out(dout_oe_b_out));

	sew_host_model sew_host_model_i (
		.mclk_in(mclk_in), .cs_out(cs_in), .serial_clk_out(serial_clk_in),
		.din_out(din_in), .dout_in(dout_line));

	// Released line shows the inverse of the last bit, so a dropped enable is caught
	assign dout_line = dout_oe_b_out ? !dout_out : dout_out;

	// ====================================================================
	// Checking and closing
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		if (n_mismatch == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ====================================================================
	// Link operations
	task automatic cmd(input logic [1:0] op, input logic [7:0] a, input logic [31:0] d, input int nd);
		sew_host_model_i.start_frame();
		sew_host_model_i.send({29'h0, 1'b1, op}, 3);
		sew_host_model_i.send({24'h0, a}, 8);
		if (nd > 0)
			sew_host_model_i.send(d, nd);
		sew_host_model_i.end_frame();
	endtask

	// Busy must read low right after launch, then ready within a bound
	task automatic status();
		int k;
		sew_host_model_i.raise_cs();
		check({14'h0, dout_out, dout_oe_b_out}, 16'h0000);
		k = 0;
		while (dout_out !== 1'b1 && k < 8 * PROG_CYC) begin
			sew_host_model_i.tick(1);
			k++;
		end
		check({14'h0, dout_out, dout_oe_b_out}, 16'h0002);
		sew_host_model_i.end_frame();
	endtask

	// Nonzero lz adds leading zeros and a stopped clock in mid-address
	task automatic rd(input logic [7:0] a, input int n, input logic [47:0] exp, input int lz);
		logic        b0;
		logic        b1;
		logic        prev;
		logic        stable;
		logic [15:0] w;
		sew_host_model_i.start_frame();
		sew_host_model_i.send(32'h0, lz);
		sew_host_model_i.send({29'h0, 1'b1, `SEW_OP_READ}, 3);
		sew_host_model_i.send({28'h0, a[7:4]}, 4);
		if (lz > 0)
			sew_host_model_i.tick(40);
		sew_host_model_i.send({28'h0, a[3:0]}, 4);
		check({14'h0, dout_out, dout_oe_b_out}, 16'h0000);
		prev = dout_out;
		for (int i = 0; i < n; i++) begin
			stable = 1'b1;
			for (int j = 0; j < 16; j++) begin
				sew_host_model_i.rise_read(b0, b1);
				stable &= (b0 === prev);
				prev = b1;
				w = {w[14:0], b1};
			end
			check(w, exp[47 - 16 * i -: 16]);
			check({15'h0, stable}, 16'h0001);
		end
		sew_host_model_i.end_frame();
	endtask

	// ====================================================================
	// Scenarios
	task automatic t_refused();
		cmd(`SEW_OP_WRITE, 8'h03, 32'h1234, 16);
		sew_host_model_i.raise_cs();
		check({15'h0, dout_oe_b_out}, 16'h0001);
		sew_host_model_i.end_frame();
	endtask

	task automatic t_program();
		cmd(`SEW_OP_EXT, {`SEW_SUB_ENABLE, 6'h00}, 32'h0, 0);
		cmd(`SEW_OP_EXT, {`SEW_SUB_FILL, 6'h2a}, 32'h5a5a, 16);
		status();
		cmd(`SEW_OP_WRITE, 8'hff, 32'h1111, 16);
		status();
		cmd(`SEW_OP_WRITE, 8'h00, 32'hf2222, 20);
		status();
		rd(8'hff, 3, 48'h1111_2222_5a5a, 3);
		cmd(`SEW_OP_ERASE, 8'h00, 32'h0, 0);
		status();
		rd(8'h00, 2, {`SEW_ERASED, 16'h5a5a, 16'h0}, 0);
	endtask

	task automatic t_status_clear();
		cmd(`SEW_OP_WRITE, 8'h01, 32'h0f0f, 16);
		sew_host_model_i.start_frame();
		sew_host_model_i.send(32'h1, 1);
		check({15'h0, dout_oe_b_out}, 16'h0001);
		sew_host_model_i.end_frame();
		sew_host_model_i.tick(8 * PROG_CYC);
		rd(8'h01, 1, 48'h0f0f_0000_0000, 0);
	endtask

	task automatic t_lock();
		cmd(`SEW_OP_EXT, {`SEW_SUB_LOCK, 6'h15}, 32'h0, 0);
		t_refused();
		cmd(`SEW_OP_ERASE, 8'h01, 32'h0, 0);
		sew_host_model_i.start_frame();
		sew_host_model_i.send(32'h35, 6);
		sew_host_model_i.end_frame();
		rd(8'h01, 3, 48'h0f0f_5a5a_5a5a, 0);
	endtask

	task automatic t_clear_all();
		cmd(`SEW_OP_EXT, {`SEW_SUB_ENABLE, 6'h3f}, 32'h0, 0);
		cmd(`SEW_OP_EXT, {`SEW_SUB_CLEAR, 6'h00}, 32'h0, 0);
		status();
		rd(8'h80, 2, {`SEW_ERASED, `SEW_ERASED, 16'h0}, 0);
	endtask

	// ====================================================================
	// Main sequence and watchdog
	initial begin
		repeat (3) @(posedge mclk_in);
		#1;
		rst_b_in = 1'b1;
		sew_host_model_i.tick(2);
		t_refused();
		t_program();
		t_status_clear();
		t_lock();
		t_clear_all();
		print_verdict();
	end

	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_mismatch++;
			print_verdict();
		end
	end
endmodule

`default_nettype wire
